// ### hdl/spc_ctrl.sv
// controller-mode serial port, clock phase cleared, with a transmit FIFO
// assumes format, delay and control words are held steady by software
`timescale 1ns/100ps
`include "spc_map.svh"

module spc_ctrl (
  input  wire logic                   sys_clk,            // 125 MHz clock
  input  wire logic                   sys_rst,            // async reset, high
  input  wire logic                   global_control_reg, // controller mode select
  input  wire logic [17:0]            format_reg,         // length, prescale, phase, pol
  input  wire logic [15:0]            delay_reg,          // setup and hold delays
  input  wire logic                   select_hold_enable, // keep select between words
  input  wire logic [`SPC_WORD_W-1:0] tx_data,            // word to send
  input  wire logic                   tx_valid,           // word offered
  output logic                        tx_ready,           // FIFO has room
  output logic [`SPC_WORD_W-1:0]      rx_data,            // received word
  output logic                        rx_valid,           // received word pulse
  output logic                        busy,               // transfer in progress
  output logic                        serial_clock_pin,   // serial clock out
  output logic                        controller_out_data,// serial data out
  input  wire logic                   controller_in_data, // serial data in
  output logic                        chip_select_n       // peripheral select, low
);
  spc_pkg::spc_ctrl_t s;
  spc_pkg::spc_ctrl_t next_s;
  logic [`SPC_WORD_W-1:0] fifo_data;
  logic                   fifo_valid;
  logic                   mode_ok;
  logic [4:0]             len;
  logic [`SPC_WORD_W-1:0] shifted;

  localparam spc_pkg::spc_ctrl_t RST_S = '{st: spc_pkg::SPC_IDLE,
                                           cs_n: `SPC_RST_CS_N, default: '0};

  // half period; prescale 0 gives a two-cycle period, 255 gives 256 cycles
  function automatic logic [7:0] half_of(input logic [7:0] ps);
    half_of = {1'b0, ps[7:1]} + 8'h01;
  endfunction

  function automatic logic [4:0] len_of(input logic [4:0] f);
    if (f < `SPC_LEN_MIN)
      len_of = `SPC_LEN_MIN;
    else if (f > `SPC_LEN_MAX)
      len_of = `SPC_LEN_MAX;
    else
      len_of = f;
  endfunction

  function automatic logic top_bit(input logic [`SPC_WORD_W-1:0] w, input logic [4:0] l);
    top_bit = w[4'(l - 5'h01)];
  endfunction

  function automatic logic [`SPC_CNT_W-1:0] setup_of(input logic [7:0] c2t, input logic hold);
    setup_of = {1'b0, c2t} + (hold ? `SPC_SETUP_HOLD : `SPC_SETUP_BASE);
  endfunction

  spc_fifo #(
    .WIDTH(`SPC_WORD_W),
    .DEPTH(`SPC_FIFO_DEPTH)
  ) spc_fifo_inst (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .in_data  (tx_data),
    .in_valid (tx_valid),
    .in_ready (tx_ready),
    .out_data (fifo_data),
    .out_valid(fifo_valid),
    .out_ready(s.take)
  );

  always_comb
  begin
    next_s      = s;
    next_s.take = 1'b0;
    next_s.rx_valid = 1'b0;
    mode_ok = global_control_reg && !format_reg[`SPC_FMT_PHASE_BIT];
    len     = len_of(format_reg[`SPC_FMT_LEN_HI:`SPC_FMT_LEN_LO]);
    shifted = s.tx_sh << 1;
    case (s.st)
      spc_pkg::SPC_IDLE:
      begin
        next_s.pol  = format_reg[`SPC_FMT_POL_BIT];
        next_s.sclk = format_reg[`SPC_FMT_POL_BIT];
        if (mode_ok && fifo_valid)
        begin
          next_s.st   = spc_pkg::SPC_LOAD;
          next_s.take = 1'b1;
        end
      end
      spc_pkg::SPC_LOAD:
      begin
        next_s.len   = len;
        next_s.bits  = len;
        next_s.half  = half_of(format_reg[`SPC_FMT_PS_HI:`SPC_FMT_PS_LO]);
        next_s.t2c   = delay_reg[`SPC_DLY_T2C_HI:`SPC_DLY_T2C_LO];
        next_s.tx_sh = fifo_data;
        next_s.rx_sh = '0;
        next_s.mosi  = top_bit(fifo_data, len);
        next_s.cs_n  = 1'b0;
        next_s.cnt   = setup_of(delay_reg[`SPC_DLY_C2T_HI:`SPC_DLY_C2T_LO],
                                select_hold_enable) - 1'b1;
        next_s.st    = spc_pkg::SPC_SETUP;
      end
      spc_pkg::SPC_SETUP:
      begin
        if (s.cnt != '0)
          next_s.cnt = s.cnt - 1'b1;
        else
        begin
          next_s.sclk  = ~s.pol;
          next_s.rx_sh = {s.rx_sh[`SPC_WORD_W-2:0], controller_in_data};
          next_s.cnt   = {1'b0, s.half} - 1'b1;
          next_s.st    = spc_pkg::SPC_SHIFT;
        end
      end
      spc_pkg::SPC_SHIFT:
      begin
        if (s.cnt != '0)
          next_s.cnt = s.cnt - 1'b1;
        else if (s.sclk == s.pol)
        begin
          next_s.sclk  = ~s.pol;
          next_s.rx_sh = {s.rx_sh[`SPC_WORD_W-2:0], controller_in_data};
          next_s.cnt   = {1'b0, s.half} - 1'b1;
        end
        else
        begin
          next_s.sclk = s.pol;
          if (s.bits == 5'h01)
          begin
            next_s.cnt      = {1'b0, s.half} + {1'b0, s.t2c} + `SPC_HOLD_BASE - 1'b1;
            next_s.rx_data  = s.rx_sh;
            next_s.rx_valid = 1'b1;
            next_s.st       = spc_pkg::SPC_HOLD;
          end
          else
          begin
            next_s.tx_sh = shifted;
            next_s.mosi  = top_bit(shifted, s.len);
            next_s.bits  = s.bits - 1'b1;
            next_s.cnt   = {1'b0, s.half} - 1'b1;
          end
        end
      end
      spc_pkg::SPC_HOLD:
      begin
        if (s.cnt != '0)
          next_s.cnt = s.cnt - 1'b1;
        else if (select_hold_enable && mode_ok && fifo_valid)
        begin
          // select stays low into the next word
          next_s.st   = spc_pkg::SPC_LOAD;
          next_s.take = 1'b1;
        end
        else
        begin
          next_s.cs_n = 1'b1;
          next_s.st   = spc_pkg::SPC_IDLE;
        end
      end
      default:
        next_s = RST_S;
    endcase
    next_s.busy = (next_s.st != spc_pkg::SPC_IDLE);
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      s <= RST_S;
    else
      s <= next_s;
  end

  assign rx_data             = s.rx_data;
  assign rx_valid            = s.rx_valid;
  assign busy                = s.busy;
  assign serial_clock_pin    = s.sclk;
  assign controller_out_data = s.mosi;
  assign chip_select_n       = s.cs_n;

  // helper counters: cycles since clock toggled, and since select went active or a word was loaded
  logic [`SPC_CNT_W:0] gap;
  logic [`SPC_CNT_W:0] cs_age;
  // leading edges launched since the word was loaded
  logic [4:0]          lead_n;
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gap    <= '0;
      cs_age <= '0;
      lead_n <= 5'h00;
    end
    else
    begin
      gap    <= (next_s.sclk != s.sclk) ? '0 : gap + 1'b1;
      cs_age <= (s.cs_n || s.st == spc_pkg::SPC_LOAD) ? '0 : cs_age + 1'b1;
      lead_n <= (s.st == spc_pkg::SPC_LOAD) ? 5'h00
                : lead_n + 5'((next_s.sclk != s.sclk) && (next_s.sclk != s.pol));
    end
  end

  half_period_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ($changed(serial_clock_pin) && $past(s.st) == spc_pkg::SPC_SHIFT)
      |-> $past(gap) == {2'b00, s.half} - 1'b1)
    else $error("serial clock half period wrong");

  prescale_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ($rose(serial_clock_pin) && !s.pol && s.st == spc_pkg::SPC_SHIFT
      && format_reg[`SPC_FMT_PS_HI:`SPC_FMT_PS_LO] == 8'h00) |=> $fell(serial_clock_pin))
    else $error("two-cycle period not kept");

  setup_wait_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ($changed(serial_clock_pin) && $past(s.st) == spc_pkg::SPC_SETUP)
      |-> cs_age == {2'b00, $past(delay_reg[`SPC_DLY_C2T_HI:`SPC_DLY_C2T_LO])}
                    + (select_hold_enable ? 10'h003 : 10'h002))
    else $error("select to clock wait wrong");

  hold_time_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ($rose(chip_select_n) && $past(s.st) == spc_pkg::SPC_HOLD)
      |-> gap == {2'b00, s.half} + {2'b00, s.t2c} + 10'h001)
    else $error("select hold wrong");

  mode_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (s.st == spc_pkg::SPC_IDLE && (format_reg[`SPC_FMT_PHASE_BIT] || !global_control_reg))
      |=> s.st == spc_pkg::SPC_IDLE)
    else $error("transfer started outside controller phase-zero mode");

  idle_level_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (chip_select_n && s.st == spc_pkg::SPC_IDLE)
      |=> serial_clock_pin == $past(format_reg[`SPC_FMT_POL_BIT]))
    else $error("clock not at idle level");

  // data moves only when a word is loaded or on a trailing edge
  data_change_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $changed(controller_out_data) |-> ($past(s.st) == spc_pkg::SPC_LOAD
      || ($changed(serial_clock_pin) && serial_clock_pin == s.pol)))
    else $error("data changed off the trailing edge");

  word_end_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rx_valid |-> (s.st == spc_pkg::SPC_HOLD && serial_clock_pin == s.pol
      && lead_n == s.len) ##1 !rx_valid)
    else $error("received word pulse malformed");
endmodule

// ### hdl/spc_map.svh
// constants for the controller-mode serial port: field positions, counts, resets
// assumes the format, delay and global control words arrive as plain ports
// Function
// - nonzero prescale: period at least prescale plus one
// - zero prescale: period exactly two cycles
// - timing applies in controller mode, phase cleared
// - polarity bit picks idle level and active edge
// - no hold: select, then setup delay plus two
// - hold enabled: setup delay plus three cycles
// - select held half period, hold delay, one
// - both delays come from one delay register
// - clock high and low halves are equal
// - data changes on trailing edge, half early
// - words of 2 to 16 bits shift
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

`define SPC_WORD_W        16
`define SPC_FIFO_DEPTH    16
`define SPC_CNT_W         9

`define SPC_GCR_CTRL_BIT  0
`define SPC_FMT_LEN_HI    4
`define SPC_FMT_LEN_LO    0
`define SPC_FMT_PS_HI     15
`define SPC_FMT_PS_LO     8
`define SPC_FMT_PHASE_BIT 16
`define SPC_FMT_POL_BIT   17
`define SPC_DLY_C2T_HI    15
`define SPC_DLY_C2T_LO    8
`define SPC_DLY_T2C_HI    7
`define SPC_DLY_T2C_LO    0

`define SPC_LEN_MIN       5'h02
`define SPC_LEN_MAX       5'h10
`define SPC_SETUP_BASE    9'h002
`define SPC_SETUP_HOLD    9'h003
`define SPC_HOLD_BASE     9'h001

`define SPC_RST_CS_N      1'b1

`endif

// ### hdl/spc_pkg.sv
// types of the controller-mode serial port
// assumes spc_map.svh is on the include path
`include "spc_map.svh"

package spc_pkg;

  typedef enum logic [2:0] {
    SPC_IDLE,
    SPC_LOAD,
    SPC_SETUP,
    SPC_SHIFT,
    SPC_HOLD
  } spc_state_t;

  typedef struct packed {
    spc_state_t            st;
    logic [`SPC_CNT_W-1:0] cnt;
    logic [4:0]            bits;
    logic [4:0]            len;
    logic [7:0]            half;
    logic [7:0]            t2c;
    logic                  pol;
    logic                  sclk;
    logic                  mosi;
    logic                  cs_n;
    logic                  take;
    logic [`SPC_WORD_W-1:0] tx_sh;
    logic [`SPC_WORD_W-1:0] rx_sh;
    logic [`SPC_WORD_W-1:0] rx_data;
    logic                  rx_valid;
    logic                  busy;
  } spc_ctrl_t;

endpackage

// ### hdl/spc_fifo.sv
// word FIFO in flip-flops, valid/ready on both sides
// assumes one clock; depth is a power of two
`timescale 1ns/100ps

module spc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,   // system clock
  input  wire logic             sys_rst,   // async reset, high
  input  wire logic [WIDTH-1:0] in_data,   // word to store
  input  wire logic             in_valid,  // word offered
  output logic                  in_ready,  // room left
  output logic [WIDTH-1:0]      out_data,  // head word
  output logic                  out_valid, // head word present
  input  wire logic             out_ready  // head word taken
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [CW-1:0]               cnt;
    logic                        in_ready;
  } spc_fifo_t;

  spc_fifo_t s;
  spc_fifo_t next_s;
  logic      push;
  logic      pop;

  always_comb
  begin
    next_s = s;
    push   = in_valid && s.in_ready;
    pop    = out_ready && (s.cnt != '0);
    if (push)
    begin
      next_s.mem[s.wr] = in_data;
      next_s.wr        = s.wr + 1'b1;
    end
    if (pop)
      next_s.rd = s.rd + 1'b1;
    if (push && !pop)
      next_s.cnt = s.cnt + 1'b1;
    else if (pop && !push)
      next_s.cnt = s.cnt - 1'b1;
    // registered so the source sees ready straight from a flop
    next_s.in_ready = (next_s.cnt != CW'(DEPTH));
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      s <= '{in_ready: 1'b1, default: '0};
    else
      s <= next_s;
  end

  assign in_ready  = s.in_ready;
  assign out_data  = s.mem[s.rd];
  assign out_valid = (s.cnt != '0);

  fifo_bound_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !s.in_ready |-> s.cnt == CW'(DEPTH))
    else $error("fifo refuses words while not full");
endmodule

// ### dv/spc_periph.sv
// peripheral model for the far side of the serial port, clock phase cleared
// assumes select, clock and data come straight from the controller
`timescale 1ns/100ps

module spc_periph (
  input  wire logic       sclk, // serial clock
  input  wire logic       cs_n, // select, low
  input  wire logic       mosi, // data from controller
  input  wire logic       pol,  // idle clock level
  input  wire logic [4:0] len,  // word length, 2..16
  output logic            miso, // data to controller
  output logic [15:0]     got   // last word received
);
  logic [15:0] sh = 16'h0000;
  logic [15:0] rw;
  logic        last = 1'b0;
  int          nb = 0;
  int          ob = 0;
  int          fr = 0;
  int          ofr = 0;
  initial got = 16'h0000;
  always @(negedge cs_n)
  begin
    nb = 0;
    ob = 0;
  end
  always @(sclk)
  begin
    if (!cs_n && sclk !== pol)
    begin
      sh = {sh[14:0], mosi};
      nb++;
      if (nb == int'(len))
      begin
        got = sh;
        nb = 0;
        fr++;
      end
    end
    else if (!cs_n)
    begin
      ob = nb;
      ofr = fr;
    end
  end
  always_comb rw = 16'hA5C3 ^ 16'(ofr * 32'h0000_1111);
  always @(miso) if (!cs_n) last = miso;
  // a released line shows the inverse of its last bit, so a stale value cannot pass
  assign miso = cs_n ? ~last : rw[len - 5'h01 - 5'(ob)];
endmodule

// ### dv/spc_ctrl_bench.sv
// self-checking bench for the controller-mode serial port
// assumes spc_periph answers on the serial side
`timescale 1ns/100ps
`include "spc_map.svh"

module spc_ctrl_bench;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        global_control_reg = 1'b0;
  logic [17:0] format_reg = 18'h00000;
  logic [15:0] delay_reg = 16'h0000;
  logic        select_hold_enable = 1'b0;
  logic [15:0] tx_data = 16'h0000;
  logic        tx_valid = 1'b0;
  logic        tx_ready, rx_valid, busy, serial_clock_pin, controller_out_data;
  logic        controller_in_data, chip_select_n, pcs = 1'b1, psck, pmosi, first;
  logic [15:0] rx_data, got, mask = 16'h0003;
  logic [31:0] seed = 32'h5586CB63;
  logic [31:0] e;
  logic [31:0] q[$];
  logic [4:0]  leff = 5'h02;
  int          hh, su, t2c, k, t_fall = -1, t_edge = 0, t_mosi = 0;
  int          nsent = 0, n_fail = 0, checks = 0, cyc = 0, n_fall = 0;

  spc_ctrl spc_ctrl_inst (.sys_clk, .sys_rst, .global_control_reg, .format_reg, .delay_reg,
    .select_hold_enable, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .busy,
    .serial_clock_pin, .controller_out_data, .controller_in_data, .chip_select_n);
  spc_periph spc_periph_inst (.sclk(serial_clock_pin), .cs_n(chip_select_n),
    .mosi(controller_out_data), .pol(format_reg[17]), .len(leff), .miso(controller_in_data),
    .got(got));

  always #4 sys_clk = ~sys_clk;

  function automatic logic [15:0] lfsr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction
  function automatic logic [15:0] reply(int f);
    return 16'hA5C3 ^ 16'(f * 32'h0000_1111);
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(logic [15:0] g, logic [15:0] x);
    checks++;
    if (g !== x)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic tick(int i);
    if (i == 20000)
    begin
      n_fail++;
      test_done();
    end
    else
      @(negedge sys_clk);
  endtask
  task automatic cfg(logic [4:0] l, logic [7:0] ps, logic p, logic [15:0] d, logic h,
                     logic m, logic ph);
    @(negedge sys_clk);
    format_reg = {p, ph, ps, 3'h0, l};
    delay_reg = d;
    select_hold_enable = h;
    global_control_reg = m;
    leff = (l < 5'h02) ? 5'h02 : (l > 5'h10) ? 5'h10 : l;
    mask = 16'((32'h1 << leff) - 32'h1);
    hh = int'(ps[7:1]) + 1;
    su = int'(d[15:8]) + (h ? 3 : 2);
    t2c = int'(d[7:0]);
  endtask
  task automatic fill(int n);
    for (int j = 0; j < n; j++)
    begin
      @(negedge sys_clk);
      tx_data = lfsr();
      tx_valid = 1'b1;
      for (int i = 0; tx_ready !== 1'b1; i++) tick(i);
      q.push_back({tx_data & mask, reply(nsent) & mask});
      nsent++;
    end
    @(negedge sys_clk);
    tx_valid = 1'b0;
  endtask
  task automatic drain();
    for (int i = 0; q.size() != 0 || busy !== 1'b0 || chip_select_n !== 1'b1; i++) tick(i);
  endtask

  // timing is measured in clock cycles between changes seen at the pins
  always @(negedge sys_clk)
  begin
    cyc++;
    // taken first so data moving on a leading edge shows a zero distance
    if (controller_out_data !== pmosi) t_mosi = cyc;
    if (!sys_rst && pcs && !chip_select_n)
    begin
      t_fall = cyc;
      n_fall++;
      first = 1'b1;
      chk(16'(serial_clock_pin), 16'(format_reg[17]));
    end
    if (!sys_rst && serial_clock_pin !== psck && serial_clock_pin !== format_reg[17])
    begin
      if (first && t_fall >= 0) chk(16'(cyc - t_fall), 16'(su));
      if (!first) chk(16'(cyc - t_edge), 16'(hh));
      if (!first) chk(16'(cyc - t_mosi >= hh), 16'h0001);
      first = 1'b0;
      t_edge = cyc;
    end
    else if (!sys_rst && serial_clock_pin !== psck && !chip_select_n)
    begin
      chk(16'(cyc - t_edge), 16'(hh));
      t_edge = cyc;
    end
    if (!sys_rst && !pcs && chip_select_n) chk(16'(cyc - t_edge), 16'(hh + t2c + 1));
    if (rx_valid === 1'b1)
    begin
      first = 1'b1;
      t_fall = -1;
      if (q.size() == 0)
        chk(16'h0001, 16'h0000);
      else
      begin
        e = q.pop_front();
        chk(rx_data, e[15:0]);
        chk(got & mask, e[31:16]);
      end
    end
    pcs = chip_select_n;
    psck = serial_clock_pin;
    pmosi = controller_out_data;
  end

  initial
  begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    cfg(5'h02, 8'h02, 1'b0, 16'h0000, 1'b0, 1'b1, 1'b0);
    fill(2);
    drain();
    cfg(5'h10, 8'h03, 1'b1, 16'h0000, 1'b0, 1'b1, 1'b0);
    fill(2);
    drain();
    cfg(5'h05, 8'h06, 1'b0, 16'h0305, 1'b0, 1'b1, 1'b0);
    fill(2);
    drain();
    cfg(5'h09, 8'hFF, 1'b1, 16'hFF02, 1'b0, 1'b1, 1'b0);
    fill(1);
    drain();
    for (k = 0; k < 32; k++)
    begin
      cfg(5'(k), 8'h02, k[0], 16'h0101, 1'b0, 1'b1, 1'b0);
      fill(1);
      drain();
    end
    cfg(5'h08, 8'h04, 1'b0, 16'h0201, 1'b1, 1'b1, 1'b0);
    k = n_fall;
    fill(3);
    drain();
    chk(16'(n_fall - k), 16'h0001);
    cfg(5'h04, 8'h02, 1'b0, 16'h0000, 1'b0, 1'b0, 1'b0);
    fill(16);
    @(negedge sys_clk);
    tx_data = lfsr();
    tx_valid = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(16'(tx_ready), 16'h0000);
    chk(16'(busy), 16'h0000);
    tx_valid = 1'b0;
    cfg(5'h04, 8'h02, 1'b0, 16'h0000, 1'b0, 1'b1, 1'b1);
    repeat (40) @(negedge sys_clk);
    chk(16'(busy), 16'h0000);
    cfg(5'h04, 8'h02, 1'b0, 16'h0000, 1'b0, 1'b1, 1'b0);
    drain();
    test_done();
  end
endmodule
